// >>> rdd_pkg.sv
// shared constants and types for the registered ddr module command path
package rdd_pkg;
  // widths of the module pins, auto precharge bit position and counter width
  localparam int ROW_W = 13;
  localparam int COL_W = 11;
  localparam int DATA_W = 64;
  localparam int CHECK_W = 8;
  localparam int MASK_W = 9;
  localparam int NBANK = 4;
  localparam int AP_BIT = 10;
  localparam int CNT_W = 3;
  // buffered write word: bank, column, mask, check bits, data
  localparam int WORD_W = 2 + COL_W + MASK_W + CHECK_W + DATA_W;
  localparam int WBUF_DEPTH = 2;
  // latencies in clock cycles
  localparam int COMP_LAT_CYC = 2;
  localparam int REG_LAT_CYC = 1;
  localparam int READ_LAT_CYC = COMP_LAT_CYC + REG_LAT_CYC;
  // half-cycle latency rounds up to a whole cycle at this clock
  localparam int READ_LAT_HALF_CYC = READ_LAT_CYC + 1;
  localparam int FLOAT_CYC = 3;
  localparam int FLOAT_HALF_CYC = 4;
  localparam int WRITE_DATA_LAT_CYC = 2;
  // counter loads derived from the latencies
  localparam logic [CNT_W-1:0] RD_WAIT_LOAD = CNT_W'(READ_LAT_CYC - 1);
  localparam logic [CNT_W-1:0] RD_WAIT_HALF_LOAD = CNT_W'(READ_LAT_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] FLOAT_LOAD = CNT_W'(FLOAT_CYC - 1);
  localparam logic [CNT_W-1:0] FLOAT_HALF_LOAD = CNT_W'(FLOAT_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] WR_WAIT_LOAD = CNT_W'(WRITE_DATA_LAT_CYC - 1);
  // beats per burst, one beat per cycle
  localparam logic [1:0] BSEL_2 = 2'h1;
  localparam logic [1:0] BSEL_4 = 2'h2;
  localparam logic [CNT_W-1:0] BEATS_2 = 3'h1;
  localparam logic [CNT_W-1:0] BEATS_4 = 3'h2;
  localparam logic [CNT_W-1:0] BEATS_8 = 3'h4;
  // command codes as {row strobe, column strobe, write enable}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  typedef enum logic [1:0] {PS_ACTIVE, PS_PDOWN, PS_SREF} rdd_pwr_e;
endpackage

// >>> rdd_buf_if.sv
// valid/ready handshake bundle between the command path and its write buffer
`timescale 1ns/1ps
`default_nettype none
interface rdd_buf_if #(parameter int W = 8) ();
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport store (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface
`default_nettype wire

// >>> rdd_two_buf.sv
// shift-style buffer whose head entry drives the output straight from flops
`timescale 1ns/1ps
`default_nettype none
module rdd_two_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic nrst,
  rdd_buf_if.store b
);
  logic [W-1:0] ent_reg [DEPTH];
  logic [DEPTH-1:0] vld_reg;
  logic [DEPTH-1:0] vld_next;
  logic [DEPTH:0] vld_sh;
  logic [DEPTH:0] vld_lo;
  wire logic pop = vld_reg[0] & b.out_ready;
  // full only when the last slot holds a word, so the source sees it at once
  wire logic push = b.in_valid & ~vld_reg[DEPTH-1];

  // handshake outputs come from flops: ready from the last slot, valid and data from the head
  assign b.in_ready = ~vld_reg[DEPTH-1];
  assign b.out_valid = vld_reg[0];
  assign b.out_data = ent_reg[0];
  assign vld_sh = pop ? {2'h0, vld_reg[DEPTH-1:1]} : {1'h0, vld_reg};
  assign vld_lo = {vld_sh[DEPTH-1:0], 1'h1};

  // each entry moves one place towards the head on a pop
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic [W-1:0] moved;
    wire logic slot = push & ~vld_sh[i] & vld_lo[i];
    if (i + 1 < DEPTH) begin : g_mid
      assign moved = pop ? ent_reg[i+1] : ent_reg[i];
    end else begin : g_last
      assign moved = ent_reg[i];
    end
    assign vld_next[i] = vld_sh[i] | slot;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        ent_reg[i] <= '0;
      end else begin
        ent_reg[i] <= slot ? b.in_data : moved;
      end
    end
  end

  // occupancy flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vld_reg <= '0;
    end else begin
      vld_reg <= vld_next;
    end
  end
endmodule
`default_nettype wire

// >>> rdd_cmd_timing.sv
// command decode, bank state and data timing of a registered ddr memory module
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R01] controller spaces write and precharge, same bank
// [R02] controller spaces read and precharge by half-burst
// [R03] controller waits after write before a read
// [R04] controller waits after burst stop before write
// [R05] data floats fixed cycles after burst stop
// [R06] controller spaces read and following write
// [R07] data floats fixed cycles after precharge
// [R08] write data taken two cycles after command
// [R09] controller waits two cycles after mode set
// [R10] controller waits after self refresh exit
// [R11] read only 200 cycles after self refresh
// [R12] power-down entry one cycle, exit gap one
// [R13] chip select high ignores inputs, bursts continue
// [R14] strobe levels decode the command
// [R15] capture row on activate, column on access
// [R16] precharge all or selected bank by address bit
// [R17] address bit enables auto precharge on access
// [R18] bank number is high*2 plus low
// [R19] clock enable low enters, high leaves low power
// [R20] controller holds clock enable one full cycle
// [R21] reset clears input registers, outputs low
// [R22] read latency is component latency plus one
// [R23] module drives strobe on reads only
// [R24] controller refreshes every 7.8 us on average
module rdd_cmd_timing
  import rdd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ROW_W-1:0] addr,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic cke,
  input wire logic read_latency_half,
  input wire logic [1:0] burst_length_sel,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [CHECK_W-1:0] check_bits_in,
  input wire logic [MASK_W-1:0] data_mask_in,
  input wire logic dqs_in,
  output logic [DATA_W-1:0] dq_out,
  output logic [CHECK_W-1:0] check_bits_out,
  output logic dq_oe,
  output logic dqs_out,
  output logic dqs_oe,
  input wire logic [DATA_W+CHECK_W-1:0] rd_word,
  output logic rd_req,
  output logic [1:0] rd_bank,
  output logic [ROW_W-1:0] rd_row,
  output logic [COL_W-1:0] rd_col,
  output logic rd_auto_pre,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [WORD_W-1:0] wr_word,
  output logic wr_full,
  output logic [NBANK-1:0] bank_open,
  output logic power_down,
  output logic self_refresh,
  output logic refresh_pulse,
  output logic mode_set_pulse
);
  logic cs_n_reg, ras_n_reg, cas_n_reg, we_n_reg, cke_reg, dqs_reg, rl_half_reg;
  logic [ROW_W-1:0] addr_reg;
  logic [1:0] bs_reg, bsel_reg;
  logic [DATA_W-1:0] dq_reg;
  logic [CHECK_W-1:0] chk_reg;
  logic [MASK_W-1:0] mask_reg;
  rdd_pwr_e pwr_reg, pwr_next;
  logic power_down_reg, self_refresh_reg, refresh_pulse_reg, mode_set_pulse_reg;
  logic [CNT_W-1:0] rd_wait_reg, rd_wait_next, rd_beats_reg, rd_beats_next;
  logic [CNT_W-1:0] stop_wait_reg, stop_wait_next;
  logic [CNT_W-1:0] wr_wait_reg, wr_wait_next, wr_beats_reg, wr_beats_next;
  logic dq_oe_reg, oe_next, dqs_oe_reg, dqs_out_reg;
  logic [DATA_W+CHECK_W-1:0] dq_out_reg;
  logic rd_req_reg, rd_ap_reg, wr_ap_reg, wr_full_reg;
  logic [1:0] rd_bank_reg, wr_bank_reg;
  logic [ROW_W-1:0] rd_row_reg;
  logic [COL_W-1:0] rd_col_reg, wr_col_reg;
  logic [NBANK-1:0] open_vec;
  logic [ROW_W-1:0] row_vec [NBANK];

  // [R21] [R22] input register stage, cleared to low by reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_n_reg <= 1'h0;
      ras_n_reg <= 1'h0;
      cas_n_reg <= 1'h0;
      we_n_reg <= 1'h0;
      cke_reg <= 1'h0;
      dqs_reg <= 1'h0;
      rl_half_reg <= 1'h0;
      addr_reg <= '0;
      bs_reg <= 2'h0;
      bsel_reg <= 2'h0;
      dq_reg <= '0;
      chk_reg <= '0;
      mask_reg <= '0;
    end else begin
      cs_n_reg <= cs_n;
      ras_n_reg <= ras_n;
      cas_n_reg <= cas_n;
      we_n_reg <= we_n;
      cke_reg <= cke;
      dqs_reg <= dqs_in;
      rl_half_reg <= read_latency_half;
      addr_reg <= addr;
      bs_reg <= {bank_select_high, bank_select_low};
      bsel_reg <= burst_length_sel;
      dq_reg <= dq_in;
      chk_reg <= check_bits_in;
      mask_reg <= data_mask_in;
    end
  end

  // [R14] command from the three strobe levels
  wire logic [2:0] cmd = {ras_n_reg, cas_n_reg, we_n_reg};
  // [R13] chip select gates commands, not running bursts
  wire logic cmd_ok = ~cs_n_reg & cke_reg & (pwr_reg == PS_ACTIVE);
  wire logic act_go = cmd_ok & (cmd == CMD_ACT);
  wire logic rd_go = cmd_ok & (cmd == CMD_RD);
  wire logic wr_go = cmd_ok & (cmd == CMD_WR);
  wire logic pre_go = cmd_ok & (cmd == CMD_PRE);
  wire logic bst_go = cmd_ok & (cmd == CMD_BST);
  wire logic ref_go = cmd_ok & (cmd == CMD_REF);
  wire logic mrs_go = cmd_ok & (cmd == CMD_MRS);
  wire logic ap_bit = addr_reg[AP_BIT];
  // [R18] bank number from the two selects
  wire logic [1:0] bank_sel = bs_reg;
  // [R15] column from the low ten bits and bit 11
  wire logic [COL_W-1:0] col_sel = {addr_reg[11], addr_reg[9:0]};
  wire logic [CNT_W-1:0] beats_per_burst =
    (bsel_reg == BSEL_2) ? BEATS_2 : (bsel_reg == BSEL_4) ? BEATS_4 : BEATS_8;
  wire logic rd_busy = (rd_wait_reg != '0) | dq_oe_reg;
  // [R05] [R07] burst stop or precharge of the read bank cuts the read
  wire logic stop_go = rd_busy & (bst_go | (pre_go & (ap_bit | (bank_sel == rd_bank_reg))));
  wire logic rd_end = (rd_beats_reg == 3'h1) & (rd_wait_reg != 3'h1) & (stop_wait_reg != 3'h1);
  wire logic wr_end = (wr_beats_reg == 3'h1) & (wr_wait_reg != 3'h1);

  // [R16] [R17] per-bank open flag and row, closed by precharge or auto precharge
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic open_reg;
    logic [ROW_W-1:0] row_reg;
    wire logic hit = (bank_sel == 2'(b));
    wire logic auto_close = (rd_end & rd_ap_reg & (rd_bank_reg == 2'(b))) |
                            (wr_end & wr_ap_reg & (wr_bank_reg == 2'(b)));
    wire logic close = (pre_go & (ap_bit | hit)) | auto_close;
    assign open_vec[b] = open_reg;
    assign row_vec[b] = row_reg;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        open_reg <= 1'h0;
        row_reg <= '0;
      end else if (act_go & hit) begin
        open_reg <= 1'h1;
        row_reg <= addr_reg;
      end else if (close) begin
        open_reg <= 1'h0;
      end
    end
  end

  // [R22] [R05] [R07] read timing: latency wait, beats, float countdown
  always_comb begin
    rd_wait_next = (rd_wait_reg != '0) ? rd_wait_reg - 3'h1 : rd_wait_reg;
    rd_beats_next = rd_beats_reg;
    stop_wait_next = (stop_wait_reg != '0) ? stop_wait_reg - 3'h1 : stop_wait_reg;
    oe_next = dq_oe_reg;
    if (rd_wait_reg == 3'h1) begin
      oe_next = 1'h1;
      rd_beats_next = beats_per_burst;
    end else if (rd_beats_reg != '0) begin
      rd_beats_next = rd_beats_reg - 3'h1;
      oe_next = (rd_beats_reg != 3'h1);
    end
    if (stop_wait_reg == 3'h1) begin
      oe_next = 1'h0;
      rd_beats_next = '0;
      rd_wait_next = '0;
    end
    if (stop_go) begin
      stop_wait_next = rl_half_reg ? FLOAT_HALF_LOAD : FLOAT_LOAD;
    end
    if (rd_go) begin
      rd_wait_next = rl_half_reg ? RD_WAIT_HALF_LOAD : RD_WAIT_LOAD;
    end
  end

  // [R23] read data and strobe driven only while a read beat is out
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_wait_reg <= '0;
      rd_beats_reg <= '0;
      stop_wait_reg <= '0;
      dq_oe_reg <= 1'h0;
      dqs_oe_reg <= 1'h0;
      dqs_out_reg <= 1'h0;
      dq_out_reg <= '0;
    end else begin
      rd_wait_reg <= rd_wait_next;
      rd_beats_reg <= rd_beats_next;
      stop_wait_reg <= stop_wait_next;
      dq_oe_reg <= oe_next;
      dqs_oe_reg <= oe_next;
      dqs_out_reg <= oe_next & ~dqs_out_reg;
      dq_out_reg <= oe_next ? rd_word : '0;
    end
  end

  // [R15] [R17] read request towards the array with captured address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_req_reg <= 1'h0;
      rd_bank_reg <= 2'h0;
      rd_row_reg <= '0;
      rd_col_reg <= '0;
      rd_ap_reg <= 1'h0;
    end else begin
      rd_req_reg <= rd_go;
      if (rd_go) begin
        rd_bank_reg <= bank_sel;
        rd_row_reg <= row_vec[bank_sel];
        rd_col_reg <= col_sel;
        rd_ap_reg <= ap_bit;
      end
    end
  end

  // [R08] write data window opens a fixed two cycles after the command
  always_comb begin
    wr_wait_next = (wr_wait_reg != '0) ? wr_wait_reg - 3'h1 : wr_wait_reg;
    wr_beats_next = (wr_beats_reg != '0) ? wr_beats_reg - 3'h1 : wr_beats_reg;
    if (wr_wait_reg == 3'h1) begin
      wr_beats_next = beats_per_burst;
    end
    if (wr_go) begin
      wr_wait_next = WR_WAIT_LOAD;
    end
  end

  // write buffer bundle, declared before the flops that read its ready
  rdd_buf_if #(.W(WORD_W)) wbuf();

  // write beats carry bank and incrementing column into the buffer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_wait_reg <= '0;
      wr_beats_reg <= '0;
      wr_bank_reg <= 2'h0;
      wr_col_reg <= '0;
      wr_ap_reg <= 1'h0;
      wr_full_reg <= 1'h0;
    end else begin
      wr_wait_reg <= wr_wait_next;
      wr_beats_reg <= wr_beats_next;
      wr_full_reg <= ~wbuf.in_ready;
      if (wr_go) begin
        wr_bank_reg <= bank_sel;
        wr_col_reg <= col_sel;
        wr_ap_reg <= ap_bit;
      end else if (wr_beats_reg != '0) begin
        wr_col_reg <= wr_col_reg + 11'h1;
      end
    end
  end

  // [R23] write words are taken only with the controller's strobe high
  assign wbuf.in_valid = (wr_beats_reg != '0) & dqs_reg;
  assign wbuf.in_data = {wr_bank_reg, wr_col_reg, mask_reg, chk_reg, dq_reg};
  assign wbuf.out_ready = wr_ready;
  rdd_two_buf #(.W(WORD_W), .DEPTH(WBUF_DEPTH)) u_wbuf (
    .clk(clk),
    .nrst(nrst),
    .b(wbuf.store)
  );

  // [R19] [R12] low power states; entry takes effect at the next edge
  // relies on the controller holding clock enable a full cycle [R20]
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      PS_ACTIVE: begin
        if (!cke_reg && !cs_n_reg && cmd == CMD_REF) begin
          pwr_next = PS_SREF;
        end else if (!cke_reg && (cs_n_reg || cmd == CMD_NOP)) begin
          pwr_next = PS_PDOWN;
        end
      end
      PS_PDOWN, PS_SREF: begin
        if (cke_reg) begin
          pwr_next = PS_ACTIVE;
        end
      end
      default: pwr_next = PS_ACTIVE;
    endcase
  end

  // status flops and one-cycle command pulses
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_reg <= PS_ACTIVE;
      power_down_reg <= 1'h0;
      self_refresh_reg <= 1'h0;
      refresh_pulse_reg <= 1'h0;
      mode_set_pulse_reg <= 1'h0;
    end else begin
      pwr_reg <= pwr_next;
      power_down_reg <= (pwr_next == PS_PDOWN);
      self_refresh_reg <= (pwr_next == PS_SREF);
      refresh_pulse_reg <= ref_go;
      mode_set_pulse_reg <= mrs_go;
    end
  end

  // outputs straight from flops
  assign dq_out = dq_out_reg[DATA_W-1:0];
  assign check_bits_out = dq_out_reg[DATA_W+CHECK_W-1:DATA_W];
  assign dq_oe = dq_oe_reg;
  assign dqs_out = dqs_out_reg;
  assign dqs_oe = dqs_oe_reg;
  assign rd_req = rd_req_reg;
  assign rd_bank = rd_bank_reg;
  assign rd_row = rd_row_reg;
  assign rd_col = rd_col_reg;
  assign rd_auto_pre = rd_ap_reg;
  assign wr_valid = wbuf.out_valid;
  assign wr_word = wbuf.out_data;
  assign wr_full = wr_full_reg;
  assign bank_open = open_vec;
  assign power_down = power_down_reg;
  assign self_refresh = self_refresh_reg;
  assign refresh_pulse = refresh_pulse_reg;
  assign mode_set_pulse = mode_set_pulse_reg;

  // checks on timing and state relations
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_READ_LATENCY: assert property ( // [R22]
    (rd_go && !rl_half_reg && !rd_busy && !stop_go) |-> ##2 !dq_oe_reg ##1 dq_oe_reg)
    else $error("read data not out three cycles after read");
  AST_STOP_FLOAT: assert property ( // [R05]
    (stop_go && !rl_half_reg && dq_oe_reg && rd_beats_reg > 3'h2) |-> ##2 dq_oe_reg ##1 !dq_oe_reg)
    else $error("data lines not floated three cycles after stop");
  AST_PRE_FLOAT_HALF: assert property ( // [R07]
    (stop_go && pre_go && rl_half_reg && dq_oe_reg && rd_beats_reg == 3'h4) |-> ##3 dq_oe_reg ##1 !dq_oe_reg)
    else $error("data lines not floated at half latency");
  AST_WRITE_LATENCY: assert property ( // [R08]
    (wr_go && wr_beats_reg == 3'h0 && wr_wait_reg == 3'h0) |-> ##1 wr_beats_reg == 3'h0 ##1 wr_beats_reg != 3'h0)
    else $error("write window not opened two cycles after write");
  AST_CS_IGNORE: assert property ( // [R13]
    (cs_n_reg && !rd_end && !wr_end) |=> $stable(open_vec))
    else $error("bank state changed while deselected");
  AST_ROW_CAPTURE: assert property ( // [R15]
    act_go |=> (row_vec[$past(bank_sel)] == $past(addr_reg)) && open_vec[$past(bank_sel)])
    else $error("row not captured on activate");
  AST_COL_CAPTURE: assert property ( // [R15]
    rd_go |=> rd_req_reg && rd_col_reg == {$past(addr_reg[11]), $past(addr_reg[9:0])})
    else $error("column not captured on read");
  AST_PRE_ALL: assert property ( // [R16]
    (pre_go && ap_bit) |=> open_vec == 4'h0)
    else $error("precharge all left a bank open");
  AST_AUTO_PRE: assert property ( // [R17]
    rd_go |=> rd_ap_reg == $past(ap_bit))
    else $error("auto precharge flag not taken from address");
  AST_BANK3: assert property ( // [R18]
    (act_go && bank_sel == 2'h3) |=> open_vec[3])
    else $error("both selects high did not open bank 3");
  AST_PDOWN_ENTRY: assert property ( // [R12]
    (pwr_reg == PS_ACTIVE && !cke_reg && (cs_n_reg || cmd == CMD_NOP)) |=> power_down_reg && !$past(power_down_reg))
    else $error("power down not entered in one cycle");
  AST_WAKE: assert property ( // [R19]
    ((power_down_reg || self_refresh_reg) && cke_reg) |=> !power_down_reg && !self_refresh_reg)
    else $error("low power state kept with clock enable high");
  AST_RESET_CLEAR: assert property ( // [R21]
    disable iff (1'h0) !nrst |=> (addr_reg == '0 && !cke_reg && !dq_oe_reg && dq_reg == '0))
    else $error("input registers not cleared by reset");
  AST_STROBE_DIR: assert property ( // [R23]
    (!dq_oe_reg && rd_wait_reg != 3'h1) |=> !dqs_oe_reg)
    else $error("strobe driven outside a read burst");

  COV_READ_BURST: cover property (rd_go ##[1:8] $fell(dq_oe_reg));
  COV_WRITE_PUSH: cover property (wr_go ##[2:8] wbuf.in_valid);
  COV_SELF_REFRESH: cover property ($rose(self_refresh_reg) ##[1:20] $fell(self_refresh_reg));
  COV_STOP_READ: cover property (stop_go && dq_oe_reg);
endmodule
`default_nettype wire

// >>> rdd_array_model.sv
// array side stand-in: read words that change each cycle, write acceptance that can stall
`timescale 1ns/1ps
`default_nettype none
module rdd_array_model
  import rdd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic stall,
  output logic wr_ready,
  output logic [DATA_W+CHECK_W-1:0] rd_word
);
  logic [7:0] cnt_reg;
  // new word every cycle, so a beat sampled one edge off shows up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  assign rd_word = {9{cnt_reg}};
  // head is held back while the bench asks for a stall
  assign wr_ready = !stall;
endmodule
`default_nettype wire

// >>> tb_rdd_cmd_timing.sv
// self-checking bench for the registered ddr command path
`timescale 1ns/1ps
`default_nettype none
module tb_rdd_cmd_timing;
  import rdd_pkg::*;
  logic clk, nrst, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, cke, read_latency_half;
  logic dqs_in, stall, dq_oe, dqs_out, dqs_oe, rd_req, rd_auto_pre, wr_valid, wr_ready, wr_full;
  logic power_down, self_refresh, refresh_pulse, mode_set_pulse;
  logic [ROW_W-1:0] addr, rd_row;
  logic [1:0] burst_length_sel, rd_bank;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic [CHECK_W-1:0] check_bits_in, check_bits_out;
  logic [MASK_W-1:0] data_mask_in;
  logic [DATA_W+CHECK_W-1:0] rd_word, prev_word;
  logic [COL_W-1:0] rd_col;
  logic [WORD_W-1:0] wr_word;
  logic [NBANK-1:0] bank_open;
  logic [12:0] rows [4];
  logic [31:0] seed = 32'h38a9;
  int failures = 0, n_tests = 0, cyc = 0, beats = 0, pulses = 0, p;
  bit oe_d, full_seen;
  int exp_start[$], exp_beats[$];
  logic [26:0] exp_rq[$];
  logic [WORD_W-1:0] exp_wr[$];

  rdd_cmd_timing u_rdd_cmd_timing (.clk, .nrst, .cs_n, .ras_n, .cas_n, .we_n, .addr, .bank_select_low,
    .bank_select_high, .cke, .read_latency_half, .burst_length_sel, .dq_in, .check_bits_in, .data_mask_in,
    .dqs_in, .dq_out, .check_bits_out, .dq_oe, .dqs_out, .dqs_oe, .rd_word, .rd_req, .rd_bank, .rd_row,
    .rd_col, .rd_auto_pre, .wr_valid, .wr_ready, .wr_word, .wr_full, .bank_open, .power_down,
    .self_refresh, .refresh_pulse, .mode_set_pulse);
  rdd_array_model u_rdd_array_model (.clk, .nrst, .stall, .wr_ready, .rd_word);

  // clock and a hang guard well above the few hundred cycles needed
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(string n, logic [127:0] e, logic [127:0] s);
    n_tests++;
    if (e !== s) begin
      failures++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask

  // pins change after an edge; the register takes them one edge later (edge po)
  task automatic cmd(logic [2:0] c, logic [12:0] a, logic [1:0] b, logic k, output int po);
    @(posedge clk);
    po = cyc + 2;
    {ras_n, cas_n, we_n} <= c;
    addr <= a;
    {bank_select_high, bank_select_low} <= b;
    cke <= k;
    @(posedge clk);
    {ras_n, cas_n, we_n} <= CMD_NOP;
  endtask

  task automatic act(logic [1:0] b);
    rows[b] = 13'(rnd());
    cmd(CMD_ACT, rows[b], b, 1'b1, p);
  endtask

  // read: note address, first beat edge and beat count for the monitor
  task automatic rd(logic [1:0] b, logic ap, int nb, output int po);
    logic [12:0] a;
    a = 13'(rnd());
    a[10] = ap;
    cmd(CMD_RD, a, b, 1'b1, po);
    exp_rq.push_back({b, rows[b], a[11], a[9:0], ap});
    exp_start.push_back(po + 3 + read_latency_half);
    exp_beats.push_back(nb);
  endtask

  // write beats start two edges after the command; beats past keep are lost to a full buffer
  task automatic wr(logic [1:0] b, int nb, int keep);
    logic [12:0] a;
    logic [80:0] d;
    a = 13'(rnd());
    a[10] = 1'b0;
    cmd(CMD_WR, a, b, 1'b1, p);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      d = 81'({rnd(), rnd(), rnd()});
      {data_mask_in, check_bits_in, dq_in} <= d;
      dqs_in <= 1'b1;
      if (i < keep) exp_wr.push_back({b, {a[11], a[9:0]} + 11'(i), d});
    end
    @(posedge clk);
    dqs_in <= 1'b0;
  endtask

  // monitor: takes the oldest note whenever a result shows at the outputs
  always @(posedge clk) begin
    #1;
    if (rd_req === 1'b1) chk("rd addr", exp_rq.pop_front(), {rd_bank, rd_row, rd_col, rd_auto_pre});
    if (dq_oe === 1'b1 && !oe_d) chk("oe start", exp_start.pop_front(), cyc);
    if (dq_oe === 1'b1) begin
      chk("rd data", prev_word, {check_bits_out, dq_out});
      chk("strobe", {1'b1, beats[0] == 1'b0}, {dqs_oe, dqs_out});
      beats++;
    end
    if (dq_oe !== 1'b1 && oe_d) begin
      chk("beats", exp_beats.pop_front(), beats);
      beats = 0;
    end
    if (wr_valid === 1'b1 && wr_ready) chk("wr word", exp_wr.pop_front(), wr_word);
    if (mode_set_pulse === 1'b1 || refresh_pulse === 1'b1) pulses++;
    if (wr_full === 1'b1) full_seen = 1'b1;
    oe_d = dq_oe === 1'b1;
    prev_word = rd_word;
  end

  initial begin
    {cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, cke, read_latency_half, dqs_in, stall} = 10'h1c0;
    {addr, dq_in, check_bits_in, data_mask_in} = '0;
    burst_length_sel = 2'h2;
    nrst = 1'b0;
    idle(3);
    chk("reset", 0, {dq_oe, dqs_oe, rd_req, wr_valid, bank_open, power_down, self_refresh, wr_word});
    nrst <= 1'b1;
    cke <= 1'b1;
    idle(2);
    cmd(CMD_MRS, 13'h0, 2'h0, 1'b1, p);
    idle(2);
    cmd(CMD_REF, 13'h0, 2'h0, 1'b1, p);
    idle(3);
    chk("pulses", 2, pulses);
    act(2'h3);
    idle(2);
    chk("bank3", 4'h8, bank_open);
    $display("test decode done");
    // every burst length code at both read latencies; bank stays open without auto precharge
    for (int h = 0; h < 2; h++) begin
      for (int s = 0; s < 4; s++) begin
        burst_length_sel <= 2'(s);
        read_latency_half <= h[0];
        idle(2);
        rd(2'h3, 1'b0, s == 1 ? 1 : s == 2 ? 2 : 4, p);
        idle(10);
      end
    end
    chk("open", 4'h8, bank_open);
    $display("test read latency done");
    // stop cuts the burst to 2 beats; precharge of all at the legal gap lets 4 finish
    for (int h = 0; h < 2; h++) begin
      for (int k = 0; k < 2; k++) begin
        read_latency_half <= h[0];
        idle(2);
        rd(2'h3, 1'b0, k ? 4 : 2, p);
        idle(k ? 2 : 0);
        cmd(k ? CMD_PRE : CMD_BST, 13'h400, 2'h0, 1'b1, p);
        idle(10);
        if (k) chk("pre all", 4'h0, bank_open);
        act(2'h3);
      end
    end
    read_latency_half <= 1'b0;
    $display("test stop and float done");
    act(2'h0);
    act(2'h2);
    cmd(CMD_PRE, 13'h0, 2'h0, 1'b1, p);
    idle(2);
    chk("pre one", 4'hc, bank_open);
    rd(2'h2, 1'b1, 4, p);
    idle(10);
    chk("auto pre", 4'h8, bank_open);
    $display("test precharge done");
    // deselected stop and activate are ignored while the burst runs on
    rd(2'h3, 1'b0, 4, p);
    cs_n <= 1'b1;
    cmd(CMD_BST, 13'h0, 2'h0, 1'b1, p);
    act(2'h1);
    cs_n <= 1'b0;
    idle(8);
    chk("deselect", 4'h8, bank_open);
    $display("test chip select done");
    burst_length_sel <= 2'h2;
    wr(2'h3, 2, 2);
    idle(6);
    burst_length_sel <= 2'h3;
    stall <= 1'b1;
    wr(2'h3, 4, 2);
    idle(4);
    chk("full", 1, full_seen);
    stall <= 1'b0;
    idle(6);
    $display("test write done");
    // power-down refuses commands; clock enable high leaves it
    cke <= 1'b0;
    idle(3);
    chk("pdown", 1, power_down);
    cmd(CMD_ACT, 13'h0, 2'h1, 1'b0, p);
    cke <= 1'b1;
    idle(3);
    chk("pd exit", 5'h08, {power_down, bank_open});
    cmd(CMD_REF, 13'h0, 2'h0, 1'b0, p);
    idle(3);
    chk("sref", 1, self_refresh);
    cke <= 1'b1;
    idle(12);
    chk("sr exit", 0, self_refresh);
    $display("test power done");
    idle(10);
    chk("queues", 0, exp_rq.size() + exp_start.size() + exp_beats.size() + exp_wr.size());
    tally_and_finish();
  end
endmodule
`default_nettype wire
